/* File: design/ldw_write_port.sv */
// LED display write port: control word, display RAM entry and scan
`timescale 1ns/100ps
`include "ldw_cfg.svh"
module ldw_write_port #(
    parameter int SCAN_CYCLES = `LDW_SCAN_CYCLES
) (
    input  wire logic       clk,                   // System clock
    input  wire logic       sys_rst,               // Async reset, active high
    input  wire logic       data_in_0,             // Data bit 1 / address LSB
    input  wire logic       data_in_1,             // Data bit 2 / address bit 2
    input  wire logic       data_in_2,             // Data bit 3 / address MSB
    input  wire logic       bank_sel_data_in_3,    // Data bit 4 / bank select
    input  wire logic       power_sel_data_in_4,   // Data bit 5 / power select
    input  wire logic       decode_sel_data_in_5,  // Data bit 6 / no-decode
    input  wire logic       scheme_sel_data_in_6,  // Data bit 7 / hex or Code B
    input  wire logic       seq_sel_data_in_7,     // Decimal point / data coming
    input  wire logic       reg_select,            // High control, low RAM
    input  wire logic       write_strobe,          // Write on rising edge
    output logic      [7:0] digit_drive,           // Digit 1..8 lit, active high
    output logic            segment_a_drive,       // Segment a lit
    output logic            segment_b_drive,       // Segment b lit
    output logic            segment_c_drive,       // Segment c lit
    output logic            segment_d_drive,       // Segment d lit
    output logic            segment_e_drive,       // Segment e lit
    output logic            segment_f_drive,       // Segment f lit
    output logic            segment_g_drive,       // Segment g lit
    output logic            decimal_point_drive    // Decimal point lit
);
    //--------------------------------------------------
    // Declarations
    //--------------------------------------------------
    localparam logic [15:0] SCAN_LAST = 16'(SCAN_CYCLES - 1);

    logic [7:0]          din;
    logic                strobe_prev_reg;
    logic                wr_rise;
    logic                ctrl_wr;
    logic                ram_wr;
    ldw_pkg::ldw_ctrl_t  ctrl_reg;
    ldw_pkg::ldw_ctrl_t  ctrl_next;
    ldw_pkg::ldw_entry_t entry_reg;
    ldw_pkg::ldw_entry_t entry_next;
    logic [2:0]          seq_idx_reg;
    logic [2:0]          seq_idx_next;
    logic [2:0]          tgt_idx;
    logic [7:0]          wen;
    ldw_pkg::ldw_digit_t words [8];
    logic [15:0]         scan_cnt_reg;
    logic [15:0]         scan_cnt_next;
    logic [2:0]          scan_idx_reg;
    logic [2:0]          scan_idx_next;
    ldw_pkg::ldw_digit_t cur_word;
    logic                decode_scheme_select;
    logic [7:0]          digit_reg;
    logic [7:0]          digit_next;
    logic [6:0]          seg_reg;
    logic [6:0]          seg_next;
    logic                dp_reg;
    logic                dp_next;

    // Segment pattern gfedcba for a nibble; Code B replaces 10..15
    function automatic logic [6:0] seg_lut(input logic hex, input logic [3:0] n);
        logic [6:0] s;
        s = 7'h00;
        unique case (n)
            4'h0: s = 7'h3F;
            4'h1: s = 7'h06;
            4'h2: s = 7'h5B;
            4'h3: s = 7'h4F;
            4'h4: s = 7'h66;
            4'h5: s = 7'h6D;
            4'h6: s = 7'h7D;
            4'h7: s = 7'h07;
            4'h8: s = 7'h7F;
            4'h9: s = 7'h6F;
            4'hA: s = hex ? 7'h77 : 7'h40;
            4'hB: s = hex ? 7'h7C : 7'h79;
            4'hC: s = hex ? 7'h39 : 7'h76;
            4'hD: s = hex ? 7'h5E : 7'h38;
            4'hE: s = hex ? 7'h79 : 7'h73;
            4'hF: s = hex ? 7'h71 : 7'h00;
        endcase
        return s;
    endfunction

    //--------------------------------------------------
    // Write strobe capture
    //--------------------------------------------------
    // Gather input lines; line 7 is the decimal point or data coming
    assign din = {seq_sel_data_in_7, scheme_sel_data_in_6, decode_sel_data_in_5,
                  power_sel_data_in_4, bank_sel_data_in_3, data_in_2, data_in_1, data_in_0};

    // Rising edge of the strobe, routed by register select
    assign wr_rise = write_strobe & ~strobe_prev_reg;
    assign ctrl_wr = wr_rise & reg_select;
    assign ram_wr  = wr_rise & ~reg_select;
    assign decode_scheme_select = ctrl_reg.scheme;

    // Control word and entry sequencing
    always_comb begin
        ctrl_next    = ctrl_reg;
        entry_next   = entry_reg;
        seq_idx_next = seq_idx_reg;
        if (ctrl_wr) begin
            ctrl_next    = ldw_pkg::ldw_ctrl_t'(din);
            seq_idx_next = 3'h0;
            entry_next   = din[`LDW_CTL_SEQ_BIT] ? ldw_pkg::LDW_SEQ
                                                 : ldw_pkg::LDW_SINGLE;
        end else if (ram_wr) begin
            unique case (entry_reg)
                ldw_pkg::LDW_SEQ: begin
                    seq_idx_next = seq_idx_reg + 3'h1;
                    if (seq_idx_reg == `LDW_LAST_DIGIT) begin
                        entry_next = ldw_pkg::LDW_IDLE;
                    end
                end
                ldw_pkg::LDW_SINGLE: begin
                    entry_next = ldw_pkg::LDW_IDLE;
                end
                ldw_pkg::LDW_IDLE: begin
                    entry_next = ldw_pkg::LDW_IDLE;
                end
                default: begin
                    entry_next = ldw_pkg::LDW_IDLE;
                end
            endcase
        end
    end

    // Target digit and one-hot write enable
    always_comb begin
        tgt_idx = (entry_reg == ldw_pkg::LDW_SEQ) ? seq_idx_reg : ctrl_reg.addr;
        wen     = 8'h00;
        if (ram_wr && entry_reg != ldw_pkg::LDW_IDLE) begin
            wen[tgt_idx] = 1'b1;
        end
    end

    // Capture registers
    always_ff @(posedge clk or posedge sys_rst) begin
        if (sys_rst) begin
            strobe_prev_reg <= 1'b0;
            ctrl_reg        <= ldw_pkg::ldw_ctrl_t'(`LDW_CTL_RST);
            entry_reg       <= ldw_pkg::LDW_IDLE;
            seq_idx_reg     <= 3'h0;
        end else begin
            strobe_prev_reg <= write_strobe;
            ctrl_reg        <= ctrl_next;
            entry_reg       <= entry_next;
            seq_idx_reg     <= seq_idx_next;
        end
    end

    //--------------------------------------------------
    // Display RAM
    //--------------------------------------------------
    for (genvar i = 0; i < 8; i++) begin : g_digit
        ldw_digit_store u_store (
            .clk      (clk),
            .sys_rst  (sys_rst),
            .wr_en    (wen[i]),
            .nodecode (ctrl_reg.nodecode),
            .bank_a   (ctrl_reg.bank_a),
            .wr_data  (din),
            .word     (words[i])
        );
    end

    //--------------------------------------------------
    // Scan and segment output
    //--------------------------------------------------
    assign cur_word = words[scan_idx_reg];

    // Scan timer halts in shutdown; segments from decoder or raw bits
    always_comb begin
        scan_cnt_next = scan_cnt_reg;
        scan_idx_next = scan_idx_reg;
        digit_next    = 8'h00;
        seg_next      = 7'h00;
        dp_next       = 1'b0;
        if (ctrl_reg.power) begin
            if (scan_cnt_reg == SCAN_LAST) begin
                scan_cnt_next = 16'h0000;
                scan_idx_next = scan_idx_reg + 3'h1;
            end else begin
                scan_cnt_next = scan_cnt_reg + 16'h0001;
            end
            digit_next[scan_idx_reg] = 1'b1;
            dp_next = cur_word.dp;
            if (ctrl_reg.nodecode) begin
                seg_next = {cur_word.nib_b[2:0], cur_word.nib_a};
            end else begin
                seg_next = seg_lut(decode_scheme_select,
                                   ctrl_reg.bank_a ? cur_word.nib_a : cur_word.nib_b);
            end
        end
    end

    // Output and scan registers
    always_ff @(posedge clk or posedge sys_rst) begin
        if (sys_rst) begin
            scan_cnt_reg <= 16'h0000;
            scan_idx_reg <= 3'h0;
            digit_reg    <= 8'h00;
            seg_reg      <= 7'h00;
            dp_reg       <= 1'b0;
        end else begin
            scan_cnt_reg <= scan_cnt_next;
            scan_idx_reg <= scan_idx_next;
            digit_reg    <= digit_next;
            seg_reg      <= seg_next;
            dp_reg       <= dp_next;
        end
    end

    assign digit_drive         = digit_reg;
    assign segment_a_drive     = seg_reg[0];
    assign segment_b_drive     = seg_reg[1];
    assign segment_c_drive     = seg_reg[2];
    assign segment_d_drive     = seg_reg[3];
    assign segment_e_drive     = seg_reg[4];
    assign segment_f_drive     = seg_reg[5];
    assign segment_g_drive     = seg_reg[6];
    assign decimal_point_drive = dp_reg;

    //--------------------------------------------------
    // Assertions
    //--------------------------------------------------
    default clocking cb @(posedge clk); endclocking
    default disable iff (sys_rst);

    property p_ctrl_route;
        ctrl_wr |=> ctrl_reg == $past(din);
    endproperty
    a_ctrl_route: assert property (p_ctrl_route) else $error("control word not latched");

    property p_no_edge;
        !wr_rise |=> $stable(ctrl_reg) && $stable(entry_reg);
    endproperty
    a_no_edge: assert property (p_no_edge) else $error("state moved without strobe edge");

    property p_dp_store;
        (|wen) |=> words[$past(tgt_idx)].dp == $past(din[7]);
    endproperty
    a_dp_store: assert property (p_dp_store) else $error("decimal point not stored");

    property p_scheme;
        ctrl_wr |=> decode_scheme_select == $past(scheme_sel_data_in_6);
    endproperty
    a_scheme: assert property (p_scheme) else $error("scheme bit wrong");

    property p_nodecode;
        ctrl_reg.power && ctrl_reg.nodecode
            |=> seg_reg == $past({cur_word.nib_b[2:0], cur_word.nib_a});
    endproperty
    a_nodecode: assert property (p_nodecode) else $error("raw segment drive wrong");

    property p_shutdown;
        !ctrl_reg.power |=> digit_reg == 8'h00 && seg_reg == 7'h00 && !dp_reg && $stable(scan_cnt_reg);
    endproperty
    a_shutdown: assert property (p_shutdown) else $error("display not blanked");

    property p_single_arm;
        ctrl_wr && !din[7] |=> entry_reg == ldw_pkg::LDW_SINGLE && ctrl_reg.addr == $past(din[2:0]);
    endproperty
    a_single_arm: assert property (p_single_arm) else $error("single-digit address lost");

    property p_bank_b;
        (|wen) && !ctrl_reg.nodecode && !ctrl_reg.bank_a
            |=> words[$past(tgt_idx)].nib_b == $past(din[3:0])
                && words[$past(tgt_idx)].nib_a == $past(words[tgt_idx].nib_a);
    endproperty
    a_bank_b: assert property (p_bank_b) else $error("bank B write wrong");

    property p_onehot;
        $past(ctrl_reg.power) |-> $onehot(digit_reg);
    endproperty
    a_onehot: assert property (p_onehot) else $error("digit scan not one-hot");

    property p_dp_out;
        ctrl_reg.power |=> dp_reg == $past(cur_word.dp);
    endproperty
    a_dp_out: assert property (p_dp_out) else $error("decimal point drive wrong");

    property p_seq_step;
        ram_wr && entry_reg == ldw_pkg::LDW_SEQ
            |=> seq_idx_reg == $past(seq_idx_reg) + 3'h1;
    endproperty
    a_seq_step: assert property (p_seq_step) else $error("sequential index not advanced");

    property p_single_done;
        ram_wr && entry_reg == ldw_pkg::LDW_SINGLE && !reg_select |=> entry_reg == ldw_pkg::LDW_IDLE;
    endproperty
    a_single_done: assert property (p_single_done) else $error("single update not closed");

    c_seq_full: cover property (ram_wr && entry_reg == ldw_pkg::LDW_SEQ && seq_idx_reg == 3'h7);
    c_single:   cover property (ram_wr && entry_reg == ldw_pkg::LDW_SINGLE);
    c_nodecode: cover property (ctrl_reg.power && ctrl_reg.nodecode && digit_reg[7]);
endmodule // ldw_write_port

/* File: design/ldw_cfg.svh */
// Constants of the LED display write port: field positions, reset values, counts
`ifndef LDW_CFG_SVH
`define LDW_CFG_SVH

// Control word field positions
`define LDW_CTL_SEQ_BIT    7
`define LDW_CTL_SCHEME_BIT 6
`define LDW_CTL_NODEC_BIT  5
`define LDW_CTL_POWER_BIT  4
`define LDW_CTL_BANK_BIT   3
`define LDW_CTL_ADDR_MSB   2
`define LDW_CTL_ADDR_LSB   0

// Reset values
`define LDW_CTL_RST        8'h00
`define LDW_NIB_RST        4'h0

// Scan dwell per digit in clock cycles
`define LDW_SCAN_CYCLES    1000
`define LDW_LAST_DIGIT     3'h7

`endif

/* File: design/ldw_pkg.sv */
// Types of the LED display write port
package ldw_pkg;

    // Control word as latched from the input lines
    typedef struct packed {
        logic       seq;       // Data coming
        logic       scheme;    // High hex, low Code B
        logic       nodecode;  // High no-decode
        logic       power;     // High normal, low shutdown
        logic       bank_a;    // High bank A, low bank B
        logic [2:0] addr;      // Single-digit address
    } ldw_ctrl_t;

    // One digit of display RAM
    typedef struct packed {
        logic       dp;        // Shared decimal point
        logic [3:0] nib_b;     // Bank B, or bits 5-7 in no-decode
        logic [3:0] nib_a;     // Bank A, or bits 1-4 in no-decode
    } ldw_digit_t;

    // Data entry state
    typedef enum logic [1:0] {
        LDW_IDLE   = 2'b00,
        LDW_SEQ    = 2'b01,
        LDW_SINGLE = 2'b10
    } ldw_entry_t;

endpackage

/* File: design/ldw_digit_store.sv */
// One digit of display RAM with bank and no-decode steering
`timescale 1ns/100ps
`include "ldw_cfg.svh"
module ldw_digit_store (
    input  wire logic             clk,       // System clock
    input  wire logic             sys_rst,   // Async reset, active high
    input  wire logic             wr_en,     // Write this digit
    input  wire logic             nodecode,  // No-decode mode
    input  wire logic             bank_a,    // Bank A selected
    input  wire logic [7:0]       wr_data,   // Captured input lines
    output ldw_pkg::ldw_digit_t   word       // Stored digit
);
    ldw_pkg::ldw_digit_t word_reg;
    ldw_pkg::ldw_digit_t word_next;

    // Next word: full byte in no-decode, one nibble plus the decimal point in decoded modes
    always_comb begin
        word_next = word_reg;
        if (wr_en) begin
            word_next.dp = wr_data[7];
            if (nodecode) begin
                word_next.nib_a = wr_data[3:0];
                word_next.nib_b = {1'b0, wr_data[6:4]};
            end else if (bank_a) begin
                word_next.nib_a = wr_data[3:0];
            end else begin
                word_next.nib_b = wr_data[3:0];
            end
        end
    end

    // Storage
    always_ff @(posedge clk or posedge sys_rst) begin
        if (sys_rst) begin
            word_reg <= '{dp: 1'b0, nib_b: `LDW_NIB_RST, nib_a: `LDW_NIB_RST};
        end else begin
            word_reg <= word_next;
        end
    end

    assign word = word_reg;
endmodule // ldw_digit_store

/* File: sim/ldw_host_model.sv */
// Host bus model that writes control words and display data
`timescale 1ns/100ps
module ldw_host_model (
    input  wire logic       clk,           // System clock
    output logic      [7:0] data_lines,    // Input lines 7..0 to the device
    output logic            reg_select,    // High control, low RAM
    output logic            write_strobe   // Write on rising edge
);
    // ----------------------------------------
    // Idle bus levels
    // ----------------------------------------
    initial begin
        data_lines   = 8'h00;
        reg_select   = 1'b0;
        write_strobe = 1'b0;
    end

    // ----------------------------------------
    // One write cycle: set up, raise strobe, release
    // ----------------------------------------
    // Lines are inverted after release so stale values never look valid
    task automatic write(input logic ctrl, input logic [7:0] val);
        @(posedge clk);
        reg_select   <= ctrl;
        data_lines   <= val;
        write_strobe <= 1'b0;
        @(posedge clk);
        write_strobe <= 1'b1;
        @(posedge clk);
        write_strobe <= 1'b0;
        reg_select   <= ~ctrl;
        data_lines   <= ~val;
    endtask
endmodule // ldw_host_model

/* File: sim/led_display_write_port_tb.sv */
// Self-checking testbench of the LED display write port
`timescale 1ns/100ps
module led_display_write_port_tb;
    logic       clk;
    logic       sys_rst;
    logic [7:0] data_lines;
    logic       reg_select;
    logic       write_strobe;
    logic [7:0] digit_drive;
    logic [7:0] seg;
    int         err_total;
    int         checks;
    int         cycles;
    logic [7:0] seq_vals [8];

    // ----------------------------------------
    // Clock, reset and timeout
    // ----------------------------------------
    initial clk = 1'b0;
    always #2.5 clk = ~clk;

    always @(posedge clk) begin
        cycles <= cycles + 1;
        if (cycles == 20000) begin
            err_total++;
            test_done();
        end
    end

    // ----------------------------------------
    // Design and host model
    // ----------------------------------------
    ldw_host_model i_ldw_host_model (
        .clk          (clk),
        .data_lines   (data_lines),
        .reg_select   (reg_select),
        .write_strobe (write_strobe)
    );

    ldw_write_port #(.SCAN_CYCLES(4)) i_ldw_write_port (
        .clk                  (clk),
        .sys_rst              (sys_rst),
        .data_in_0            (data_lines[0]),
        .data_in_1            (data_lines[1]),
        .data_in_2            (data_lines[2]),
        .bank_sel_data_in_3   (data_lines[3]),
        .power_sel_data_in_4  (data_lines[4]),
        .decode_sel_data_in_5 (data_lines[5]),
        .scheme_sel_data_in_6 (data_lines[6]),
        .seq_sel_data_in_7    (data_lines[7]),
        .reg_select           (reg_select),
        .write_strobe         (write_strobe),
        .digit_drive          (digit_drive),
        .segment_a_drive      (seg[0]),
        .segment_b_drive      (seg[1]),
        .segment_c_drive      (seg[2]),
        .segment_d_drive      (seg[3]),
        .segment_e_drive      (seg[4]),
        .segment_f_drive      (seg[5]),
        .segment_g_drive      (seg[6]),
        .decimal_point_drive  (seg[7])
    );

    // ----------------------------------------
    // Compare, access and closing tasks
    // ----------------------------------------
    task automatic cmp8(input string name, input logic [7:0] exp, input logic [7:0] got);
        checks++;
        if (got !== exp) begin
            err_total++;
            $display("[ERR] %s expected %h seen %h", name, exp, got);
        end
    endtask

    // Write through the host, then let the update settle
    task automatic wr(input logic ctrl, input logic [7:0] val);
        i_ldw_host_model.write(ctrl, val);
        repeat (3) @(posedge clk);
    endtask

    // Wait for digit k to be scanned, then check its segments
    task automatic check_digit(input int k, input logic [7:0] exp);
        int n;
        n = 0;
        @(negedge clk);
        while (digit_drive !== (8'h01 << k) && n < 64) begin
            @(negedge clk);
            n++;
        end
        cmp8("digit_drive", 8'h01 << k, digit_drive);
        cmp8("segments", exp, seg);
    endtask

    task automatic test_done();
        $display("checks %0d mismatches %0d", checks, err_total);
        if (err_total == 0 && checks > 0) begin
            $display("Testbench passed");
        end else begin
            $display("Testbench failed");
        end
        $finish;
    endtask

    // ----------------------------------------
    // Test sequence
    // ----------------------------------------
    initial begin
        err_total = 0;
        checks    = 0;
        cycles    = 0;
        sys_rst   = 1'b1;
        seq_vals  = '{8'h81, 8'h42, 8'h24, 8'h18, 8'hF0, 8'h0F, 8'hA5, 8'h5A};
        repeat (16) @(posedge clk);
        sys_rst <= 1'b0;
        repeat (2) @(posedge clk);

        // Reset leaves display shut down; a stray RAM write is ignored
        wr(1'b0, 8'hFF);
        repeat (10) @(negedge clk);
        cmp8("digit_drive", 8'h00, digit_drive);
        cmp8("segments", 8'h00, seg);
        $display("test reset done");

        // Sequential no-decode fill of all eight digits, ninth write ignored
        wr(1'b1, 8'hB0);
        for (int k = 0; k < 8; k++) begin
            wr(1'b0, seq_vals[k]);
        end
        wr(1'b0, 8'hFF);
        for (int k = 0; k < 8; k++) begin
            check_digit(k, seq_vals[k]);
        end
        $display("test sequential done");

        // Single-digit update at address 6, second write ignored
        wr(1'b1, 8'h36);
        wr(1'b0, 8'h3C);
        wr(1'b0, 8'hFF);
        check_digit(6, 8'h3C);
        check_digit(5, 8'h0F);
        check_digit(7, 8'h5A);
        $display("test single done");

        // Banks in hex decode: upper lines ignored, decimal point shared
        wr(1'b1, 8'h58);
        wr(1'b0, 8'h78);
        wr(1'b1, 8'h50);
        wr(1'b0, 8'h81);
        check_digit(0, 8'h86);
        wr(1'b1, 8'h58);
        check_digit(0, 8'hFF);
        $display("test banks done");

        // Same nibble in hex then Code B
        wr(1'b1, 8'h59);
        wr(1'b0, 8'h0A);
        check_digit(1, 8'h77);
        wr(1'b1, 8'h19);
        check_digit(1, 8'h40);
        $display("test scheme done");

        // Shutdown blanks and stops the scan
        wr(1'b1, 8'h09);
        for (int i = 0; i < 12; i++) begin
            @(negedge clk);
            cmp8("digit_drive", 8'h00, digit_drive);
            cmp8("segments", 8'h00, seg);
        end
        $display("test shutdown done");
        test_done();
    end
endmodule // led_display_write_port_tb
